// ### sfhi_chk.sv
// Pin-level checker of the serial flash front end
`timescale 1ns/1ps
module sfhi_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic ready,
	input wire logic standby
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	logic [15:0] busy_r;
	logic [15:0] busy_nxt;
	// Length of the busy stretch, so a job cannot end early unseen
	assign busy_nxt = ready ? 16'h0000 : busy_r + 16'h0001;
	always_ff @(posedge ref_clk)
		busy_r <= rst_n ? busy_nxt : 16'h0000;
	a_oe_released: assert property (cs_n [*7] |-> !so_oe)
		else $error("serial output driven while deselected");
	a_standby_state: assert property (cs_n [*8] |-> standby == ready)
		else $error("standby does not follow job completion");
	a_standby_busy: assert property (!ready |-> !standby)
		else $error("standby while a job runs");
	a_ignore_desel: assert property (cs_n [*7] ##1 (cs_n && ready) |=> ready)
		else $error("job started while deselected");
	a_so_on_fall: assert property (so_oe && $changed(so) |-> !$past(sck, 2))
		else $error("output changed outside a falling clock");
	a_oe_end: assert property ($rose(cs_n) |-> ##[1:6] !so_oe)
		else $error("output still driven after select rose");
	a_oe_start: assert property ($rose(so_oe) |-> !$past(cs_n, 8) && !$past(cs_n, 32))
		else $error("output driven without an opened frame");
	a_job_launch: assert property ($fell(ready) |-> $past(cs_n, 2))
		else $error("job launched before select rose");
	a_self_timed: assert property (ready && !$past(ready) |-> busy_r >= 16'h0f9f)
		else $error("self-timed job ended too early");
	// Main scenarios: a read phase, a job, a read during a job
	cover property ($rose(so_oe));
	cover property ($fell(ready));
	cover property (!ready && $rose(so_oe));
endmodule

// ### sfhi_fifo2.sv
// Small valid/ready buffer between the read data source and the serialiser
`timescale 1ns/1ps
module sfhi_fifo2 #(
	parameter int WIDTH = sfhi_pkg::FIFO_WIDTH,
	parameter int DEPTH = sfhi_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
	localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;

	// Honest full and empty from the occupancy count
	assign in_ready = (cnt_r != FULL);
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rp_r];

	// Storage has no reset; only pointers and count need a defined state
	always_ff @(posedge clk)
	begin
		if (push)
			mem_r[wp_r] <= in_data;
	end

	// Pointers and count; flush drops anything stale from an aborted frame
	always_ff @(posedge clk)
	begin
		if (!rst_n || flush)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= (wp_r == PTR_LAST) ? '0 : AW'(wp_r + 1'b1);
			if (pop)
				rp_r <= (rp_r == PTR_LAST) ? '0 : AW'(rp_r + 1'b1);
			if (push && !pop)
				cnt_r <= (AW + 1)'(cnt_r + 1'b1);
			else if (pop && !push)
				cnt_r <= (AW + 1)'(cnt_r - 1'b1);
		end
	end
endmodule

// ### sfhi_host.sv
// Host master model: framing, bit timing and read-back on the serial link
`timescale 1ns/1ps
module sfhi_host (
	input wire logic ref_clk,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so,
	input wire logic so_oe,
	output logic [7:0] rx_byte,
	output logic rx_stb
);
	localparam int HALF = 8; // 80 ns link period at 5 ns core clock
	logic idle_hi = 1'b0;
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end
	// Select falls with the clock at its idle level, then a settle gap
	task automatic open(input logic m3);
		idle_hi = m3;
		sck <= m3;
		@(posedge ref_clk);
		cs_n <= 1'b0;
		repeat (HALF) @(posedge ref_clk);
	endtask
	// Bits MSB first; read back late in the high half, where the output is settled
	task automatic xb(input logic [7:0] tx, input logic chk, input int n = 8);
		logic [7:0] rx;
		for (int i = 7; i > 7 - n; i--)
		begin
			sck <= 1'b0;
			si <= tx[i];
			repeat (HALF) @(posedge ref_clk);
			sck <= 1'b1;
			repeat (HALF) @(posedge ref_clk);
			rx[i] = so_oe ? so : 1'bx; // Released line reads as unknown
		end
		rx_byte <= rx;
		rx_stb <= chk;
		@(posedge ref_clk);
		rx_stb <= 1'b0;
	endtask
	// Clock back to idle, then select rises; data line flips so it shows nothing stale
	task automatic close();
		sck <= idle_hi;
		repeat (HALF) @(posedge ref_clk);
		cs_n <= 1'b1;
		si <= ~si;
		repeat (2 * HALF) @(posedge ref_clk);
	endtask
	// Clock and data wiggle while deselected
	task automatic noise(input int n);
		for (int i = 0; i < n; i++)
		begin
			sck <= ~sck;
			si <= ~si;
			repeat (HALF) @(posedge ref_clk);
		end
	endtask
endmodule

// ### sfhi_pkg.sv
// Shared constants and types for the serial flash host interface front end
package sfhi_pkg;

	// Clock and self-timed cycle timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_SELF_NS = 20000;
	localparam int T_SELF_CYC = (T_SELF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TMR_W = 16;

	// Array organisation
	localparam int PAGES = 1024;
	localparam int PAGE_W = 10;
	localparam int BYTE_W = 9;
	localparam int IDX_W = 19;
	localparam logic [8:0] PAGE_BYTES_STD = 9'h108;
	localparam logic [8:0] PAGE_BYTES_BIN = 9'h100;
	localparam int MEM_BYTES = PAGES * int'(PAGE_BYTES_STD);
	localparam int BUF_BYTES = int'(PAGE_BYTES_STD);
	localparam int SEC_BYTES = 128;
	localparam int SEC_USER_BYTES = 64;
	localparam logic [8:0] SEC_USER_CNT = 9'h040;
	localparam logic [9:0] BLOCK_MASK = 10'h3f8;
	localparam logic [9:0] SECTOR_MASK = 10'h380;
	localparam logic [10:0] ONE_PAGE = 11'h001;
	localparam logic [10:0] BLOCK_PAGES = 11'h008;
	localparam logic [10:0] SECTOR_PAGES = 11'h080;
	localparam logic [10:0] CHIP_PAGES = 11'h400;
	localparam logic CFG_BIN_DEFAULT = 1'b0;

	// Address field positions inside the 24-bit address
	localparam int A_PAGE_STD_LSB = 9;
	localparam int A_PAGE_BIN_LSB = 8;

	// Serial framing
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ADDR_LAST = 2'h2;
	localparam logic [7:0] BYTE_FILL = 8'hff;
	localparam logic [7:0] BYTE_ERASED = 8'hff;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 2;

	// Opcodes (arbitrary encodings)
	localparam logic [7:0] OP_BUF_WRITE = 8'h11;
	localparam logic [7:0] OP_BUF_READ = 8'h12;
	localparam logic [7:0] OP_MEM_READ = 8'h13;
	localparam logic [7:0] OP_BUF_PROG = 8'h14;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h15;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'h16;
	localparam logic [7:0] OP_SECT_ERASE = 8'h17;
	localparam logic [7:0] OP_CHIP_ERASE = 8'h18;
	localparam logic [7:0] OP_STATUS = 8'h19;
	localparam logic [7:0] OP_READ_ID = 8'h1a;
	localparam logic [7:0] OP_SEC_READ = 8'h1b;
	localparam logic [7:0] OP_SEC_PROG = 8'h1c;
	localparam logic [7:0] OP_CFG_BIN = 8'h1d;
	localparam logic [7:0] OP_CFG_STD = 8'h1e;

	// Status byte fields
	localparam int STAT_RDY_BIT = 7;
	localparam int STAT_BIN_BIT = 0;

	// Identification codes (values are arbitrary)
	localparam logic [7:0] MFG_CODE = 8'h5a;
	localparam logic [7:0] DEV_CODE = 8'h3c;
	localparam logic [8:0] ID_LEN = 9'h002;
	localparam logic [7:0] UID_SEED = 8'ha5;

	typedef enum {SFHI_F_OPC, SFHI_F_ADDR, SFHI_F_WDATA, SFHI_F_STRM, SFHI_F_IGN} sfhi_frame_t;
	typedef enum {SFHI_S_BUF, SFHI_S_MEM, SFHI_S_STAT, SFHI_S_ID, SFHI_S_SEC} sfhi_src_t;
	typedef enum logic [1:0] {SFHI_J_PROG, SFHI_J_ERASE, SFHI_J_SEC, SFHI_J_CFG} sfhi_jkind_t;

	typedef struct packed {
		sfhi_jkind_t kind;
		logic [IDX_W-1:0] base;
		logic [IDX_W-1:0] count;
		logic cfg_bin;
	} sfhi_job_t;

	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
	} sfhi_pins_t;

	localparam sfhi_pins_t PINS_IDLE = 3'h4;
	localparam sfhi_job_t JOB_NONE = '0;

endpackage

// ### sfhi_top.sv
// Serial host interface, command core and memory store of the page flash
// Overview of operation
// - Chip select high: deselected, standby when idle, serial output released.
// - Serial input bits are ignored while chip select is high.
// - An operation starts only after chip select falls.
// - Chip select rising ends the operation and launches any pending job.
// - A self-timed job keeps running after chip select rises; standby follows completion.
// - Opcode, address and write data are sampled on serial clock rising edges.
// - Output data changes only on serial clock falling edges.
// - Modes 0 and 3 behave identically; only edges matter, not idle level.
// - Array holds 1,024 pages of 256 or 264 bytes per configured size.
// - One SRAM buffer sized to the larger 264-byte page; it wraps at the configured page size.
// - Program and erase run on an internal timer with no host clocks.
// - Erase by page, 8-page block, 128-page sector or whole chip.
// - 128-byte security area: 64 user bytes plus 64 fixed identifier bytes.
// - Identification read returns manufacturer code then device code.
// - Frame carries an 8-bit opcode first, then the address bytes.
// - Everything shifts most significant bit first both ways.
// - Reset low aborts any operation and idles the machines until released.
`timescale 1ns/1ps
module sfhi_top (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic so,
	output logic so_oe,
	output logic ready,
	output logic standby
);
	// Page and byte fields of an address for the current page size
	function automatic logic [9:0] page_of(input logic [23:0] a, input logic bin);
		page_of = bin ? a[sfhi_pkg::A_PAGE_BIN_LSB +: sfhi_pkg::PAGE_W]
			: a[sfhi_pkg::A_PAGE_STD_LSB +: sfhi_pkg::PAGE_W];
	endfunction

	function automatic logic [8:0] byte_of(input logic [23:0] a, input logic bin);
		byte_of = bin ? {1'b0, a[sfhi_pkg::A_PAGE_BIN_LSB-1:0]}
			: a[sfhi_pkg::A_PAGE_STD_LSB-1:0];
	endfunction

	// Linear store index; pages always occupy the larger stride
	function automatic logic [18:0] lin(input logic [9:0] pg, input logic [8:0] by);
		lin = 19'(19'(pg) * 19'(sfhi_pkg::PAGE_BYTES_STD)) + 19'(by);
	endfunction

	// Commands that carry three address bytes
	function automatic logic needs_addr(input logic [7:0] op);
		needs_addr = (op == sfhi_pkg::OP_BUF_WRITE) || (op == sfhi_pkg::OP_BUF_READ)
			|| (op == sfhi_pkg::OP_MEM_READ) || (op == sfhi_pkg::OP_BUF_PROG)
			|| (op == sfhi_pkg::OP_PAGE_ERASE) || (op == sfhi_pkg::OP_BLOCK_ERASE)
			|| (op == sfhi_pkg::OP_SECT_ERASE) || (op == sfhi_pkg::OP_SEC_READ)
			|| (op == sfhi_pkg::OP_SEC_PROG);
	endfunction

	// Fixed identifier half of the security area
	function automatic logic [7:0] uid_byte(input logic [6:0] i);
		uid_byte = sfhi_pkg::UID_SEED ^ {1'b0, i};
	endfunction

	sfhi_pkg::sfhi_pins_t pin_s1_r, pin_s2_r, pin_s3_r, pin_f_r;
	sfhi_pkg::sfhi_pins_t pin_f_nxt;
	sfhi_pkg::sfhi_frame_t frame_r;
	sfhi_pkg::sfhi_src_t src_r;
	sfhi_pkg::sfhi_job_t pend_job_r, job_r;
	logic [2:0] rx_cnt_r, tx_cnt_r;
	logic [7:0] rx_sh_r, tx_sh_r, op_r;
	logic [23:0] addr_r;
	logic [1:0] addr_cnt_r;
	logic [9:0] ptr_page_r;
	logic [8:0] ptr_byte_r, wr_ptr_r;
	logic pend_r, busy_r, bin_r, so_r, so_oe_r;
	logic [18:0] eng_idx_r, eng_left_r;
	logic [sfhi_pkg::TMR_W-1:0] eng_tmr_r;
	logic [7:0] mem_r [0:sfhi_pkg::MEM_BYTES-1];
	logic [7:0] buf_r [0:sfhi_pkg::BUF_BYTES-1];
	logic [7:0] sec_r [0:sfhi_pkg::SEC_USER_BYTES-1];

	// Three-stage sampling of the pins; stage one feeds only stage two
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			pin_s1_r <= sfhi_pkg::PINS_IDLE;
			pin_s2_r <= sfhi_pkg::PINS_IDLE;
			pin_s3_r <= sfhi_pkg::PINS_IDLE;
			pin_f_r <= sfhi_pkg::PINS_IDLE;
		end
		else
		begin
			pin_s1_r <= {cs_n, sck, si};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_f_r <= pin_f_nxt;
		end
	end

	// A pin level is accepted only when stages two and three agree
	wire [2:0] agree = ~(pin_s2_r ^ pin_s3_r);
	assign pin_f_nxt = (pin_s3_r & agree) | (pin_f_r & ~agree);

	// Edge detection on the filtered levels; idle clock level never matters
	wire sck_rise = ~pin_f_r.sck & pin_f_nxt.sck;
	wire sck_fall = pin_f_r.sck & ~pin_f_nxt.sck;
	wire cs_fall = pin_f_r.cs_n & ~pin_f_nxt.cs_n;
	wire cs_rise = ~pin_f_r.cs_n & pin_f_nxt.cs_n;
	wire selected = ~pin_f_r.cs_n;
	wire [8:0] page_bytes = bin_r ? sfhi_pkg::PAGE_BYTES_BIN : sfhi_pkg::PAGE_BYTES_STD;

	// Receive shifter: input counts only while selected
	wire rx_take = sck_rise & selected;
	wire [7:0] rx_byte = {rx_sh_r[6:0], pin_f_nxt.si};
	wire rx_done = rx_take & (rx_cnt_r == sfhi_pkg::BIT_LAST);
	wire [23:0] addr_full = {addr_r[15:0], rx_byte};
	wire addr_done = (frame_r == sfhi_pkg::SFHI_F_ADDR) & rx_done
		& (addr_cnt_r == sfhi_pkg::ADDR_LAST);
	wire [9:0] a_page = page_of(addr_full, bin_r);
	wire [8:0] a_byte = byte_of(addr_full, bin_r);

	// A truncated earlier frame leaves no stray bits behind
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || cs_fall)
		begin
			rx_cnt_r <= '0;
			rx_sh_r <= '0;
		end
		else if (rx_take)
		begin
			rx_cnt_r <= 3'(rx_cnt_r + 1'b1);
			rx_sh_r <= rx_byte;
		end
	end

	// Frame machine: opcode, then address, then data or streaming
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || cs_fall)
		begin
			frame_r <= sfhi_pkg::SFHI_F_OPC;
			op_r <= '0;
			addr_cnt_r <= '0;
			addr_r <= '0;
		end
		else if (rx_done)
		begin
			case (frame_r)
				sfhi_pkg::SFHI_F_OPC:
				begin
					op_r <= rx_byte;
					if (busy_r && rx_byte != sfhi_pkg::OP_STATUS)
						frame_r <= sfhi_pkg::SFHI_F_IGN;
					else if (needs_addr(rx_byte))
						frame_r <= sfhi_pkg::SFHI_F_ADDR;
					else if (rx_byte == sfhi_pkg::OP_STATUS || rx_byte == sfhi_pkg::OP_READ_ID)
						frame_r <= sfhi_pkg::SFHI_F_STRM;
					else
						frame_r <= sfhi_pkg::SFHI_F_IGN;
				end
				sfhi_pkg::SFHI_F_ADDR:
				begin
					addr_r <= addr_full;
					addr_cnt_r <= 2'(addr_cnt_r + 1'b1);
					if (addr_cnt_r == sfhi_pkg::ADDR_LAST)
					begin
						if (op_r == sfhi_pkg::OP_BUF_WRITE)
							frame_r <= sfhi_pkg::SFHI_F_WDATA;
						else if (op_r == sfhi_pkg::OP_BUF_READ || op_r == sfhi_pkg::OP_MEM_READ
							|| op_r == sfhi_pkg::OP_SEC_READ)
							frame_r <= sfhi_pkg::SFHI_F_STRM;
						else
							frame_r <= sfhi_pkg::SFHI_F_IGN;
					end
				end
				default:
					frame_r <= frame_r;
			endcase
		end
	end

	// Job capture: a program or erase waits for the closing edge of select
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || cs_fall || cs_rise)
		begin
			pend_r <= 1'b0;
			pend_job_r <= sfhi_pkg::JOB_NONE;
		end
		else if (rx_done && frame_r == sfhi_pkg::SFHI_F_OPC && !busy_r)
		begin
			pend_r <= (rx_byte == sfhi_pkg::OP_CHIP_ERASE) || (rx_byte == sfhi_pkg::OP_CFG_BIN)
				|| (rx_byte == sfhi_pkg::OP_CFG_STD);
			pend_job_r.base <= '0;
			pend_job_r.kind <= (rx_byte == sfhi_pkg::OP_CHIP_ERASE) ? sfhi_pkg::SFHI_J_ERASE
				: sfhi_pkg::SFHI_J_CFG;
			pend_job_r.count <= (rx_byte == sfhi_pkg::OP_CHIP_ERASE)
				? 19'(19'(sfhi_pkg::CHIP_PAGES) * 19'(sfhi_pkg::PAGE_BYTES_STD)) : '0;
			pend_job_r.cfg_bin <= (rx_byte == sfhi_pkg::OP_CFG_BIN);
		end
		else if (addr_done)
		begin
			pend_r <= (op_r == sfhi_pkg::OP_BUF_PROG) || (op_r == sfhi_pkg::OP_PAGE_ERASE)
				|| (op_r == sfhi_pkg::OP_BLOCK_ERASE) || (op_r == sfhi_pkg::OP_SECT_ERASE)
				|| (op_r == sfhi_pkg::OP_SEC_PROG);
			pend_job_r.cfg_bin <= bin_r;
			if (op_r == sfhi_pkg::OP_BUF_PROG)
			begin
				pend_job_r.kind <= sfhi_pkg::SFHI_J_PROG;
				pend_job_r.base <= lin(a_page, '0);
				pend_job_r.count <= 19'(page_bytes);
			end
			else if (op_r == sfhi_pkg::OP_SEC_PROG)
			begin
				pend_job_r.kind <= sfhi_pkg::SFHI_J_SEC;
				pend_job_r.base <= '0;
				pend_job_r.count <= 19'(sfhi_pkg::SEC_USER_CNT);
			end
			else if (op_r == sfhi_pkg::OP_BLOCK_ERASE)
			begin
				pend_job_r.kind <= sfhi_pkg::SFHI_J_ERASE;
				pend_job_r.base <= lin(a_page & sfhi_pkg::BLOCK_MASK, '0);
				pend_job_r.count <= lin(10'(sfhi_pkg::BLOCK_PAGES), '0);
			end
			else if (op_r == sfhi_pkg::OP_SECT_ERASE)
			begin
				pend_job_r.kind <= sfhi_pkg::SFHI_J_ERASE;
				pend_job_r.base <= lin(a_page & sfhi_pkg::SECTOR_MASK, '0);
				pend_job_r.count <= lin(10'(sfhi_pkg::SECTOR_PAGES), '0);
			end
			else
			begin
				pend_job_r.kind <= sfhi_pkg::SFHI_J_ERASE;
				pend_job_r.base <= lin(a_page, '0);
				pend_job_r.count <= lin(10'(sfhi_pkg::ONE_PAGE), '0);
			end
		end
	end

	// Self-timed engine: walk the bytes, then hold busy for the internal time
	wire job_go = cs_rise & pend_r & ~busy_r;
	wire eng_step = busy_r & (eng_left_r != '0);
	wire eng_mem_wr = eng_step & (job_r.kind == sfhi_pkg::SFHI_J_PROG
		|| job_r.kind == sfhi_pkg::SFHI_J_ERASE);
	wire eng_sec_wr = eng_step & (job_r.kind == sfhi_pkg::SFHI_J_SEC);
	wire [7:0] eng_wdata = (job_r.kind == sfhi_pkg::SFHI_J_ERASE) ? sfhi_pkg::BYTE_ERASED
		: buf_r[eng_idx_r[8:0]];

	// Reset low drops busy at once, abandoning any job in flight
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			busy_r <= 1'b0;
			job_r <= sfhi_pkg::JOB_NONE;
			eng_idx_r <= '0;
			eng_left_r <= '0;
			eng_tmr_r <= '0;
			bin_r <= sfhi_pkg::CFG_BIN_DEFAULT;
		end
		else if (job_go)
		begin
			busy_r <= 1'b1;
			job_r <= pend_job_r;
			eng_idx_r <= '0;
			eng_left_r <= pend_job_r.count;
			eng_tmr_r <= sfhi_pkg::TMR_W'(sfhi_pkg::T_SELF_CYC);
		end
		else if (eng_step)
		begin
			eng_idx_r <= 19'(eng_idx_r + 1'b1);
			eng_left_r <= 19'(eng_left_r - 1'b1);
		end
		else if (busy_r && eng_tmr_r != '0)
			eng_tmr_r <= sfhi_pkg::TMR_W'(eng_tmr_r - 1'b1);
		else if (busy_r)
		begin
			busy_r <= 1'b0;
			if (job_r.kind == sfhi_pkg::SFHI_J_CFG)
				bin_r <= job_r.cfg_bin;
		end
	end

	// Main array and user security bytes, written only by the engine
	always_ff @(posedge ref_clk)
	begin
		if (eng_mem_wr)
			mem_r[job_r.base + eng_idx_r] <= eng_wdata;
		if (eng_sec_wr)
			sec_r[eng_idx_r[5:0]] <= eng_wdata;
	end

	// Buffer loading during a write frame; address wraps at the page size
	wire buf_wr = rx_done & (frame_r == sfhi_pkg::SFHI_F_WDATA);
	always_ff @(posedge ref_clk)
	begin
		if (buf_wr)
			buf_r[wr_ptr_r] <= rx_byte;
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			wr_ptr_r <= '0;
		else if (addr_done)
			wr_ptr_r <= a_byte;
		else if (buf_wr)
			wr_ptr_r <= (wr_ptr_r == 9'(page_bytes - 1'b1)) ? '0 : 9'(wr_ptr_r + 1'b1);
	end

	// Read source selection feeding the buffer ahead of the serialiser
	wire [6:0] sec_i = ptr_byte_r[6:0];
	wire [7:0] sec_data = (ptr_byte_r < sfhi_pkg::SEC_USER_CNT) ? sec_r[sec_i[5:0]]
		: uid_byte(sec_i);
	wire [7:0] id_data = (ptr_byte_r == '0) ? sfhi_pkg::MFG_CODE
		: (ptr_byte_r == 9'h001) ? sfhi_pkg::DEV_CODE : '0;
	wire [7:0] stat_data = ({7'h00, ~busy_r} << sfhi_pkg::STAT_RDY_BIT)
		| ({7'h00, bin_r} << sfhi_pkg::STAT_BIN_BIT);
	wire [7:0] src_data = (src_r == sfhi_pkg::SFHI_S_BUF) ? buf_r[ptr_byte_r]
		: (src_r == sfhi_pkg::SFHI_S_MEM) ? mem_r[lin(ptr_page_r, ptr_byte_r)]
		: (src_r == sfhi_pkg::SFHI_S_SEC) ? sec_data
		: (src_r == sfhi_pkg::SFHI_S_ID) ? id_data : stat_data;
	wire fill_valid = (frame_r == sfhi_pkg::SFHI_F_STRM) & selected;
	wire fill_ready;
	wire fill_push = fill_valid & fill_ready;
	wire byte_wrap = (ptr_byte_r == 9'(page_bytes - 1'b1));

	// Stream pointers advance only when the buffer accepts a byte
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || cs_fall)
		begin
			src_r <= sfhi_pkg::SFHI_S_STAT;
			ptr_page_r <= '0;
			ptr_byte_r <= '0;
		end
		else if (rx_done && frame_r == sfhi_pkg::SFHI_F_OPC)
			src_r <= (rx_byte == sfhi_pkg::OP_READ_ID) ? sfhi_pkg::SFHI_S_ID : sfhi_pkg::SFHI_S_STAT;
		else if (addr_done)
		begin
			src_r <= (op_r == sfhi_pkg::OP_MEM_READ) ? sfhi_pkg::SFHI_S_MEM
				: (op_r == sfhi_pkg::OP_SEC_READ) ? sfhi_pkg::SFHI_S_SEC : sfhi_pkg::SFHI_S_BUF;
			ptr_page_r <= a_page;
			ptr_byte_r <= (op_r == sfhi_pkg::OP_SEC_READ) ? '0 : a_byte;
		end
		else if (fill_push)
		begin
			case (src_r)
				sfhi_pkg::SFHI_S_BUF:
					ptr_byte_r <= byte_wrap ? '0 : 9'(ptr_byte_r + 1'b1);
				sfhi_pkg::SFHI_S_MEM:
				begin
					ptr_byte_r <= byte_wrap ? '0 : 9'(ptr_byte_r + 1'b1);
					if (byte_wrap)
						ptr_page_r <= 10'(ptr_page_r + 1'b1); // Continues through the array
				end
				sfhi_pkg::SFHI_S_SEC:
					ptr_byte_r <= {2'h0, 7'(sec_i + 1'b1)};
				sfhi_pkg::SFHI_S_ID:
					ptr_byte_r <= (ptr_byte_r == sfhi_pkg::ID_LEN) ? ptr_byte_r : 9'(ptr_byte_r + 1'b1);
				default:
					ptr_byte_r <= ptr_byte_r;
			endcase
		end
	end

	wire tx_valid;
	wire [7:0] tx_data;
	wire tx_edge = sck_fall & selected & (frame_r == sfhi_pkg::SFHI_F_STRM);
	wire tx_load = tx_edge & (tx_cnt_r == '0);
	wire [7:0] tx_word = tx_valid ? tx_data : sfhi_pkg::BYTE_FILL;

	// Two entries absorb the gap between source latency and the serial edge
	sfhi_fifo2 #(
		.WIDTH(sfhi_pkg::FIFO_WIDTH),
		.DEPTH(sfhi_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.flush(pin_f_r.cs_n),
		.in_valid(fill_valid),
		.in_ready(fill_ready),
		.in_data(src_data),
		.out_valid(tx_valid),
		.out_ready(tx_load),
		.out_data(tx_data)
	);

	// Serialiser: new bit on each falling edge, pin released while deselected
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !selected)
		begin
			tx_cnt_r <= '0;
			tx_sh_r <= '0;
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end
		else if (tx_load)
		begin
			so_r <= tx_word[7];
			tx_sh_r <= {tx_word[6:0], 1'b0};
			tx_cnt_r <= sfhi_pkg::BIT_LAST;
			so_oe_r <= 1'b1;
		end
		else if (tx_edge)
		begin
			so_r <= tx_sh_r[7];
			tx_sh_r <= {tx_sh_r[6:0], 1'b0};
			tx_cnt_r <= 3'(tx_cnt_r - 1'b1);
		end
	end

	assign so = so_r;
	assign so_oe = so_oe_r & selected;
	assign ready = ~busy_r;
	assign standby = pin_f_r.cs_n & ~busy_r;
endmodule

// ### sfhi_top_test.sv
// Testbench top: host model drives the front end, read bytes checked from a queue
`timescale 1ns/1ps
module sfhi_top_test;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n, sck, si, so, so_oe, ready, standby, rx_stb;
	logic [7:0] rx_byte;
	logic [7:0] e_m;
	logic [7:0] exp_q[$];
	logic [7:0] d[4];
	logic [31:0] rnd = 32'h4143;
	int n_fail = 0;
	int n_tests = 0;
	int cyc = 0;
	sfhi_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
		.so(so), .so_oe(so_oe), .ready(ready), .standby(standby));
	sfhi_host h (.ref_clk(ref_clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so),
		.so_oe(so_oe), .rx_byte(rx_byte), .rx_stb(rx_stb));
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Opcode, then the 24-bit address when the command carries one
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic m3);
		h.open(m3);
		h.xb(op, 1'b0);
		if (op != sfhi_pkg::OP_STATUS && op != sfhi_pkg::OP_READ_ID
			&& op != sfhi_pkg::OP_CFG_BIN && op != sfhi_pkg::OP_CFG_STD
			&& op != sfhi_pkg::OP_CHIP_ERASE)
		begin
			h.xb(a[23:16], 1'b0);
			h.xb(a[15:8], 1'b0);
			h.xb(a[7:0], 1'b0);
		end
	endtask
	task automatic rd(input logic [7:0] e);
		exp_q.push_back(e);
		h.xb(8'h00, 1'b1);
	endtask
	task automatic stat(input logic [7:0] e);
		cmd(sfhi_pkg::OP_STATUS, 24'h0, 1'b0);
		rd(e);
		h.close();
	endtask
	// Bounded wait; a job that never ends shows up in the next status byte
	task automatic wait_ready();
		for (int k = 0; k < 6000 && ready !== 1'b1; k++)
			@(posedge ref_clk);
	endtask
	// Each received byte against the oldest expectation
	always @(posedge ref_clk)
		if (rx_stb === 1'b1)
		begin
			n_tests++;
			e_m = exp_q.pop_front();
			if (rx_byte !== e_m)
			begin
				n_fail++;
				$display("Error at %0t: got %h expected %h", $time, rx_byte, e_m);
			end
		end
	// Hang guard: the run needs about 21k cycles
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			n_fail++;
			summarize();
		end
	end
	initial
	begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		// Status twice per frame, once in each clock mode
		for (int m = 0; m < 2; m++)
		begin
			cmd(sfhi_pkg::OP_STATUS, 24'h0, m[0]);
			rd(8'h80);
			rd(8'h80);
			h.close();
		end
		cmd(sfhi_pkg::OP_READ_ID, 24'h0, 1'b0);
		rd(sfhi_pkg::MFG_CODE);
		rd(sfhi_pkg::DEV_CODE);
		h.close();
		// Five stray bits, then wiggle while deselected; next opcode must still align
		h.open(1'b1);
		h.xb(8'hff, 1'b0, 5);
		h.close();
		h.noise(16);
		stat(8'h80);
		// Buffer write wrapping past the last byte, read back in mode 3
		for (int i = 0; i < 4; i++)
		begin
			rnd = xs(rnd);
			d[i] = rnd[7:0];
		end
		cmd(sfhi_pkg::OP_BUF_WRITE, 24'h000106, 1'b0);
		for (int i = 0; i < 4; i++)
			h.xb(d[i], 1'b0);
		h.close();
		cmd(sfhi_pkg::OP_BUF_READ, 24'h000106, 1'b1);
		for (int i = 0; i < 4; i++)
			rd(d[i]);
		h.close();
		// Program the last page; status during the job shows busy
		cmd(sfhi_pkg::OP_BUF_PROG, 24'h07fe00, 1'b0);
		h.close();
		stat(8'h00);
		wait_ready();
		stat(8'h80);
		cmd(sfhi_pkg::OP_MEM_READ, 24'h07ff06, 1'b1);
		rd(d[0]);
		rd(d[1]);
		h.close();
		// Erase the same page; the bytes just read must come back erased
		cmd(sfhi_pkg::OP_PAGE_ERASE, 24'h07fe00, 1'b0);
		h.close();
		wait_ready();
		cmd(sfhi_pkg::OP_MEM_READ, 24'h07ff06, 1'b0);
		rd(sfhi_pkg::BYTE_ERASED);
		rd(sfhi_pkg::BYTE_ERASED);
		h.close();
		// Page size switch, then reset in mid-job restores idle and 264-byte pages
		cmd(sfhi_pkg::OP_CFG_BIN, 24'h0, 1'b0);
		h.close();
		wait_ready();
		stat(8'h81);
		cmd(sfhi_pkg::OP_PAGE_ERASE, 24'h000000, 1'b0);
		h.close();
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		stat(8'h80);
		summarize();
	end
endmodule
bind sfhi_top sfhi_chk chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck(sck),
	.si(si), .so(so), .so_oe(so_oe), .ready(ready), .standby(standby));
